// [hdl/regulator_pkg.sv]
// constants shared by the regulator register bank and its testbench
// assumes a two-wire slave link and a 125 MHz system clock
package regulator_pkg;

  localparam logic [7:0] REG_STATUS = 8'h01;
  localparam logic [7:0] REG_SEL_HIGH = 8'h10;
  localparam logic [7:0] REG_SEL_LOW = 8'h11;

  localparam logic [7:0] RST_STATUS = 8'h00;
  localparam logic [7:0] RST_SEL_HIGH = 8'h97;
  localparam logic [7:0] RST_SEL_LOW = 8'hBF;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;

  localparam int BIT_THERMAL = 7;
  localparam int BIT_GOOD = 0;
  localparam int BIT_GATE = 7;
  localparam int CODE_W = 7;
  localparam int BANK_W = 2;
  localparam int UV_W = 23;

  localparam logic [6:0] SLAVE_ADDR = 7'h1C;
  localparam int FAST_MODE_KBPS = 400;
  localparam int SYS_CLK_MHZ = 125;

  // target in microvolts: base plus step per code
  localparam logic [UV_W-1:0] TGT_BASE_UV = 23'h04A015;
  localparam logic [UV_W-1:0] TGT_STEP_UV = 23'h000C35;

endpackage

// [hdl/bit_sync.sv]
// two-flop synchroniser for a bundle of independent levels
// assumes each bit is a level or toggle that may change at any time
`timescale 1ns/1ps
module bit_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] hold_r;

  always_ff @(posedge clk) begin
    meta_r <= din;
    hold_r <= meta_r;
  end

  assign dout = hold_r;
endmodule

// [hdl/regulator_control_registers.sv]
// regulator control and status registers behind a two-wire slave
// assumes scl/sda and analog flags arrive asynchronously; link logic on linkClk
`timescale 1ns/1ps

// What this block does
// RULE_01: status bit 7 reads 1 while die is over thermal trip, else 0; resets 0.
// RULE_02: status bit 0 reads 1 when output is in range, 0 below 90 percent.
// RULE_03: with select pin high, bit 7 of high_select_enable_and_target gates the enable pin.
// RULE_04: with select pin low, bit 7 of low_select_enable_and_target gates the enable pin.
// RULE_05: converter runs only when enable pin high and selected gate bit set.
// RULE_06: target is (303.125mV + 3.125mV * code) times two to the bank.
// RULE_07: select pin picks code and bank from high_select_enable_and_target and high bank, or low_select_enable_and_target and low bank.
// RULE_08: registers reached as a two-wire slave at address 0011100.
// RULE_09: slave keeps up with fast-mode transfers up to 400 kb/s.
// RULE_10: status reads have no side effects; writes to status are ignored.
module regulator_control_registers
  import regulator_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic clkEn,
  input wire logic linkClk,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic enPin,
  input wire logic voltageSelectPin,
  input wire logic thermalTripIn,
  input wire logic outputGoodIn,
  input wire logic [BANK_W-1:0] rangeBankHigh,
  input wire logic [BANK_W-1:0] rangeBankLow,
  output logic converterEnable,
  output logic [CODE_W-1:0] targetCode,
  output logic [BANK_W-1:0] targetBank,
  output logic [UV_W-1:0] targetMicrovolts
);

  typedef enum logic [2:0] {
    LK_IDLE, LK_ADDR, LK_PTR, LK_WDATA, LK_ACK, LK_RDATA, LK_RACK
  } link_state_e;

  function automatic logic [UV_W-1:0] targetUv(input logic [CODE_W-1:0] code,
                                               input logic [BANK_W-1:0] bank);
    logic [UV_W-1:0] base;
    base = TGT_BASE_UV + UV_W'(TGT_STEP_UV * {16'h0000, code});
    return base << bank;
  endfunction

  // link-domain registers visible to the system domain
  logic wrTog_r, wrTog_nxt;
  logic [7:0] wrAddr_r, wrAddr_nxt;
  logic [7:0] wrData_r, wrData_nxt;
  logic snapReq_r, snapReq_nxt;
  // system-domain registers visible to the link domain
  logic snapAck_r, snapAck_nxt;
  logic [23:0] snap_r, snap_nxt;

  // ---------------- system domain ----------------
  logic enS, vselS, thS, pgS, wrTogS, snapReqS;
  logic [BANK_W-1:0] bankHS, bankLS;

  bit_sync #(.WIDTH(10)) u_sys_sync (
    .clk(sys_clk),
    .din({enPin, voltageSelectPin, thermalTripIn, outputGoodIn, rangeBankHigh,
          rangeBankLow, wrTog_r, snapReq_r}),
    .dout({enS, vselS, thS, pgS, bankHS, bankLS, wrTogS, snapReqS})
  );

  logic [7:0] status_r, status_nxt;
  logic [7:0] selHigh_r, selHigh_nxt;
  logic [7:0] selLow_r, selLow_nxt;
  logic wrSeen_r, wrSeen_nxt;
  logic convEn_r, convEn_nxt;
  logic [CODE_W-1:0] tgtCode_r, tgtCode_nxt;
  logic [BANK_W-1:0] tgtBank_r, tgtBank_nxt;
  logic [UV_W-1:0] tgtUv_r, tgtUv_nxt;
  logic wrEvent;
  logic gateSel;
  logic [CODE_W-1:0] codeSel;
  logic [BANK_W-1:0] bankSel;
  logic [CODE_W-1:0] hiCode, loCode;

  assign wrEvent = wrTogS != wrSeen_r;
  assign gateSel = vselS ? selHigh_r[BIT_GATE] : selLow_r[BIT_GATE]; // RULE_03 RULE_04
  assign codeSel = vselS ? selHigh_r[CODE_W-1:0] : selLow_r[CODE_W-1:0]; // RULE_07
  assign bankSel = vselS ? bankHS : bankLS; // RULE_07
  assign hiCode = selHigh_r[CODE_W-1:0];
  assign loCode = selLow_r[CODE_W-1:0];

  always_comb begin
    status_nxt = status_r;
    selHigh_nxt = selHigh_r;
    selLow_nxt = selLow_r;
    wrSeen_nxt = wrSeen_r;
    snapAck_nxt = snapAck_r;
    snap_nxt = snap_r;
    convEn_nxt = convEn_r;
    tgtCode_nxt = tgtCode_r;
    tgtBank_nxt = tgtBank_r;
    tgtUv_nxt = tgtUv_r;
    if (clkEn) begin
      status_nxt = {thS, 6'h00, pgS}; // RULE_01 RULE_02
      wrSeen_nxt = wrTogS;
      if (wrEvent) begin
        case (wrAddr_r)
          REG_SEL_HIGH: selHigh_nxt = wrData_r;
          REG_SEL_LOW: selLow_nxt = wrData_r;
          default: ; // RULE_10
        endcase
      end
      if (snapReqS != snapAck_r) begin
        snap_nxt = {status_r, selHigh_r, selLow_r};
        snapAck_nxt = snapReqS;
      end
      convEn_nxt = enS & gateSel; // RULE_05
      tgtCode_nxt = codeSel;
      tgtBank_nxt = bankSel;
      tgtUv_nxt = targetUv(codeSel, bankSel); // RULE_06
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      status_r <= RST_STATUS;
      selHigh_r <= RST_SEL_HIGH;
      selLow_r <= RST_SEL_LOW;
      wrSeen_r <= 1'b0;
      snapAck_r <= 1'b0;
      snap_r <= {RST_STATUS, RST_SEL_HIGH, RST_SEL_LOW};
      convEn_r <= 1'b0;
      tgtCode_r <= RST_SEL_LOW[CODE_W-1:0];
      tgtBank_r <= '0;
      tgtUv_r <= '0;
    end else begin
      status_r <= status_nxt;
      selHigh_r <= selHigh_nxt;
      selLow_r <= selLow_nxt;
      wrSeen_r <= wrSeen_nxt;
      snapAck_r <= snapAck_nxt;
      snap_r <= snap_nxt;
      convEn_r <= convEn_nxt;
      tgtCode_r <= tgtCode_nxt;
      tgtBank_r <= tgtBank_nxt;
      tgtUv_r <= tgtUv_nxt;
    end
  end

  assign converterEnable = convEn_r;
  assign targetCode = tgtCode_r;
  assign targetBank = tgtBank_r;
  assign targetMicrovolts = tgtUv_r;

  // ---------------- link domain ----------------
  logic sclS, sdaS, snapAckS, enL, rstL;

  bit_sync #(.WIDTH(5)) u_link_sync (
    .clk(linkClk),
    .din({sclIn, sdaIn, snapAck_r, clkEn, srst}),
    .dout({sclS, sdaS, snapAckS, enL, rstL})
  );

  link_state_e st_r, st_nxt, ackNext_r, ackNext_nxt;
  logic sclD_r, sclD_nxt, sdaD_r, sdaD_nxt;
  logic [2:0] bitCnt_r, bitCnt_nxt;
  logic [7:0] shift_r, shift_nxt;
  logic [7:0] ptr_r, ptr_nxt;
  logic gotByte_r, gotByte_nxt;
  logic sdaOe_r, sdaOe_nxt;
  logic sdaOut_r;
  logic nack_r, nack_nxt;
  logic [23:0] linkSnap_r, linkSnap_nxt;
  logic sclRise, sclFall, startCond, stopCond, sdaMayMove;

  function automatic logic [7:0] readByte(input logic [7:0] ptr, input logic [23:0] snap);
    case (ptr)
      REG_STATUS: readByte = snap[23:16];
      REG_SEL_HIGH: readByte = snap[15:8];
      REG_SEL_LOW: readByte = snap[7:0];
      default: readByte = RD_UNMAPPED;
    endcase
  endfunction

  // oversampled bus events
  assign sclRise = sclS & ~sclD_r; // RULE_09
  assign sclFall = ~sclS & sclD_r;
  assign startCond = sclS & sclD_r & sdaD_r & ~sdaS;
  assign stopCond = sclS & sclD_r & ~sdaD_r & sdaS;
  assign sdaMayMove = sclFall | startCond | stopCond | rstL;

  always_comb begin
    st_nxt = st_r;
    ackNext_nxt = ackNext_r;
    sclD_nxt = sclD_r;
    sdaD_nxt = sdaD_r;
    bitCnt_nxt = bitCnt_r;
    shift_nxt = shift_r;
    ptr_nxt = ptr_r;
    gotByte_nxt = gotByte_r;
    sdaOe_nxt = sdaOe_r;
    nack_nxt = nack_r;
    wrTog_nxt = wrTog_r;
    wrAddr_nxt = wrAddr_r;
    wrData_nxt = wrData_r;
    snapReq_nxt = snapReq_r;
    linkSnap_nxt = linkSnap_r;
    if (enL) begin
      sclD_nxt = sclS;
      sdaD_nxt = sdaS;
      if (snapAckS == snapReq_r) begin
        linkSnap_nxt = snap_r; // RULE_10
        snapReq_nxt = ~snapReq_r;
      end
      if (stopCond) begin
        st_nxt = LK_IDLE;
        sdaOe_nxt = 1'b0;
      end else if (startCond) begin
        st_nxt = LK_ADDR; // RULE_08
        bitCnt_nxt = 3'h0;
        gotByte_nxt = 1'b0;
        sdaOe_nxt = 1'b0;
      end else begin
        case (st_r)
          LK_ADDR, LK_PTR, LK_WDATA: begin
            if (sclRise) begin
              shift_nxt = {shift_r[6:0], sdaS};
              bitCnt_nxt = bitCnt_r + 3'h1;
              gotByte_nxt = bitCnt_r == 3'h7;
            end else if (sclFall && gotByte_r) begin
              gotByte_nxt = 1'b0;
              bitCnt_nxt = 3'h0;
              sdaOe_nxt = 1'b1;
              st_nxt = LK_ACK;
              ackNext_nxt = LK_WDATA;
              if (st_r == LK_ADDR) begin
                if (shift_r[7:1] != SLAVE_ADDR) begin
                  sdaOe_nxt = 1'b0; // RULE_08
                  st_nxt = LK_IDLE;
                end else begin
                  ackNext_nxt = shift_r[0] ? LK_RDATA : LK_PTR;
                end
              end else if (st_r == LK_PTR) begin
                ptr_nxt = shift_r;
              end else begin
                wrAddr_nxt = ptr_r;
                wrData_nxt = shift_r;
                wrTog_nxt = ~wrTog_r;
                ptr_nxt = ptr_r + 8'h01;
              end
            end
          end
          LK_ACK: begin
            if (sclFall) begin
              sdaOe_nxt = 1'b0;
              st_nxt = ackNext_r;
              bitCnt_nxt = 3'h0;
              if (ackNext_r == LK_RDATA) begin
                shift_nxt = readByte(ptr_r, linkSnap_r);
                sdaOe_nxt = ~shift_nxt[7];
                ptr_nxt = ptr_r + 8'h01;
              end
            end
          end
          LK_RDATA: begin
            if (sclFall) begin
              bitCnt_nxt = bitCnt_r + 3'h1;
              if (bitCnt_r == 3'h7) begin
                sdaOe_nxt = 1'b0;
                st_nxt = LK_RACK;
              end else begin
                shift_nxt = {shift_r[6:0], 1'b0};
                sdaOe_nxt = ~shift_r[6];
              end
            end
          end
          LK_RACK: begin
            if (sclRise) begin
              nack_nxt = sdaS;
            end else if (sclFall) begin
              if (nack_r) begin
                st_nxt = LK_IDLE;
              end else begin
                shift_nxt = readByte(ptr_r, linkSnap_r);
                sdaOe_nxt = ~shift_nxt[7];
                ptr_nxt = ptr_r + 8'h01;
                bitCnt_nxt = 3'h0;
                st_nxt = LK_RDATA;
              end
            end
          end
          default: st_nxt = LK_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge linkClk) begin
    if (rstL) begin
      st_r <= LK_IDLE;
      ackNext_r <= LK_IDLE;
      sclD_r <= 1'b1;
      sdaD_r <= 1'b1;
      bitCnt_r <= 3'h0;
      shift_r <= 8'h00;
      ptr_r <= 8'h00;
      gotByte_r <= 1'b0;
      sdaOe_r <= 1'b0;
      sdaOut_r <= 1'b0;
      nack_r <= 1'b1;
      wrTog_r <= 1'b0;
      wrAddr_r <= 8'h00;
      wrData_r <= 8'h00;
      snapReq_r <= 1'b0;
      linkSnap_r <= {RST_STATUS, RST_SEL_HIGH, RST_SEL_LOW};
    end else begin
      st_r <= st_nxt;
      ackNext_r <= ackNext_nxt;
      sclD_r <= sclD_nxt;
      sdaD_r <= sdaD_nxt;
      bitCnt_r <= bitCnt_nxt;
      shift_r <= shift_nxt;
      ptr_r <= ptr_nxt;
      gotByte_r <= gotByte_nxt;
      sdaOe_r <= sdaOe_nxt;
      sdaOut_r <= 1'b0;
      nack_r <= nack_nxt;
      wrTog_r <= wrTog_nxt;
      wrAddr_r <= wrAddr_nxt;
      wrData_r <= wrData_nxt;
      snapReq_r <= snapReq_nxt;
      linkSnap_r <= linkSnap_nxt;
    end
  end

  assign sdaOe = sdaOe_r;
  assign sdaOut = sdaOut_r;

  // ---------------- checks ----------------
  sequence sStatusWrite;
    clkEn && wrEvent && (wrAddr_r == REG_STATUS);
  endsequence

  sequence sHighWrite;
    clkEn && wrEvent && (wrAddr_r == REG_SEL_HIGH);
  endsequence

  a_thermal_flag: assert property (@(posedge sys_clk) disable iff (srst) // RULE_01
    clkEn |=> status_r[BIT_THERMAL] == $past(thS)) else $error("thermal flag wrong");

  a_good_flag: assert property (@(posedge sys_clk) disable iff (srst) // RULE_02
    clkEn |=> (status_r[BIT_GOOD] == $past(pgS)) && (status_r[6:1] == 6'h00))
    else $error("output good flag wrong");

  a_gate_high: assert property (@(posedge sys_clk) disable iff (srst) // RULE_03
    (clkEn && vselS && !selHigh_r[BIT_GATE]) |=> !convEn_r)
    else $error("high gate did not block enable");

  a_gate_low: assert property (@(posedge sys_clk) disable iff (srst) // RULE_04
    (clkEn && !vselS && !selLow_r[BIT_GATE]) |=> !convEn_r)
    else $error("low gate did not block enable");

  a_enable_and: assert property (@(posedge sys_clk) disable iff (srst) // RULE_05
    clkEn |=> convEn_r == ($past(enS) && $past(gateSel)))
    else $error("converter enable mismatch");

  a_target_value: assert property (@(posedge sys_clk) disable iff (srst) // RULE_06
    clkEn |=> tgtUv_r == targetUv($past(codeSel), $past(bankSel)))
    else $error("target voltage mismatch");

  a_select_source: assert property (@(posedge sys_clk) disable iff (srst) // RULE_07
    clkEn |=> (tgtCode_r == ($past(vselS) ? $past(hiCode) : $past(loCode)))
      && (tgtBank_r == ($past(vselS) ? $past(bankHS) : $past(bankLS))))
    else $error("code or bank from wrong register");

  a_high_write: assert property (@(posedge sys_clk) disable iff (srst) // RULE_03
    sHighWrite |=> selHigh_r == $past(wrData_r)) else $error("high register not written");

  a_status_nowrite: assert property (@(posedge sys_clk) disable iff (srst) // RULE_10
    sStatusWrite |=> $stable(selHigh_r) && $stable(selLow_r))
    else $error("status write disturbed registers");

  a_addr_ignore: assert property (@(posedge linkClk) disable iff (rstL) // RULE_08
    (enL && st_r == LK_ADDR && gotByte_r && sclFall && !startCond && !stopCond
      && shift_r[7:1] != SLAVE_ADDR) |=> (st_r == LK_IDLE) && !sdaOe_r)
    else $error("answered a foreign address");

  a_addr_ack: assert property (@(posedge linkClk) disable iff (rstL) // RULE_08
    (enL && st_r == LK_ADDR && gotByte_r && sclFall && !startCond && !stopCond
      && shift_r[7:1] == SLAVE_ADDR) |=> (st_r == LK_ACK) && sdaOe_r)
    else $error("own address not acknowledged");

  a_sda_timing: assert property (@(posedge linkClk) disable iff (rstL) // RULE_09
    $changed(sdaOe_r) |-> $past(sdaMayMove)) else $error("sda moved while scl high");

endmodule

// [verification/two_wire_host_model.sv]
// behavioural two-wire bus master that drives the register bank's link pins
// assumes an external pull-up; the bench resolves the line from all pull-downs
`timescale 1ns/1ps
module two_wire_host_model (
  input wire logic clk,
  input wire logic sdaLine,
  output logic sclLine,
  output logic sdaLow
);
  // quarter bit: 4 x 79 x 8 ns keeps the bit rate just under fast mode
  localparam int QTR = 79;
  int nackCount;

  initial begin
    sclLine = 1'b1;
    sdaLow = 1'b0;
    nackCount = 0;
  end

  task qwait();
    repeat (QTR) @(posedge clk);
  endtask

  // data changes only while the clock line is low
  task put_bit(input logic b, output logic got);
    sdaLow <= ~b;
    qwait();
    sclLine <= 1'b1;
    qwait();
    got = sdaLine;
    qwait();
    sclLine <= 1'b0;
    qwait();
  endtask

  // start or repeated start: data falls while clock is high
  task start();
    sdaLow <= 1'b0;
    qwait();
    sclLine <= 1'b1;
    qwait();
    sdaLow <= 1'b1;
    qwait();
    sclLine <= 1'b0;
    qwait();
  endtask

  task stop();
    sdaLow <= 1'b1;
    qwait();
    sclLine <= 1'b1;
    qwait();
    sdaLow <= 1'b0;
    qwait();
  endtask

  // byte out msb first, then release for the slave's acknowledge
  task send(input logic [7:0] d);
    logic dummy;
    logic ack;
    for (int i = 7; i >= 0; i--) begin
      put_bit(d[i], dummy);
    end
    put_bit(1'b1, ack);
    if (ack !== 1'b0) begin
      nackCount++;
    end
  endtask

  // byte in with line released; last byte answered with a nack
  task recv(input logic last, output logic [7:0] q);
    logic dummy;
    for (int i = 7; i >= 0; i--) begin
      put_bit(1'b1, q[i]);
    end
    put_bit(last, dummy);
  endtask
endmodule

// [verification/regulator_control_registers_tb.sv]
// self-checking bench for the regulator register bank over its two-wire link
// assumes the host model file is compiled first and a pull-up on the data line
`timescale 1ns/1ps
module regulator_control_registers_tb;
  import regulator_pkg::*;

  logic sys_clk;
  logic linkClk;
  logic srst;
  logic clkEn;
  logic enPin;
  logic voltageSelectPin;
  logic thermalTripIn;
  logic outputGoodIn;
  logic [BANK_W-1:0] rangeBankHigh;
  logic [BANK_W-1:0] rangeBankLow;
  logic sdaOe;
  logic sdaOut;
  logic converterEnable;
  logic [CODE_W-1:0] targetCode;
  logic [BANK_W-1:0] targetBank;
  logic [UV_W-1:0] targetMicrovolts;
  logic sclLine;
  logic sdaLow;
  wire sdaLine;
  logic [15:0] rd;
  int err_count;
  int samples_checked;

  // open-drain line: low if anyone pulls, pulled up otherwise
  assign sdaLine = ~(sdaLow | sdaOe);

  regulator_control_registers u_dut (
    .sys_clk(sys_clk), .srst(srst), .clkEn(clkEn), .linkClk(linkClk),
    .sclIn(sclLine), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .enPin(enPin), .voltageSelectPin(voltageSelectPin),
    .thermalTripIn(thermalTripIn), .outputGoodIn(outputGoodIn),
    .rangeBankHigh(rangeBankHigh), .rangeBankLow(rangeBankLow),
    .converterEnable(converterEnable), .targetCode(targetCode),
    .targetBank(targetBank), .targetMicrovolts(targetMicrovolts)
  );

  two_wire_host_model u_host (
    .clk(sys_clk), .sdaLine(sdaLine), .sclLine(sclLine), .sdaLow(sdaLow)
  );

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  initial begin
    linkClk = 1'b0;
    #1.7;
    forever #3 linkClk = ~linkClk;
  end

  task complete_run();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  function automatic logic [22:0] exp_uv(input logic [6:0] c, input logic [1:0] b);
    exp_uv = (23'h04A015 + 23'h000C35 * {16'h0000, c}) << b;
  endfunction

  // two bytes per access; the pointer advances after each byte
  task reg_write(input logic [7:0] ptr, input logic [15:0] d);
    u_host.start();
    u_host.send({7'h1C, 1'b0});
    u_host.send(ptr);
    u_host.send(d[15:8]);
    u_host.send(d[7:0]);
    u_host.stop();
  endtask

  task reg_read(input logic [7:0] ptr, output logic [15:0] d);
    u_host.start();
    u_host.send({7'h1C, 1'b0});
    u_host.send(ptr);
    u_host.start();
    u_host.send({7'h1C, 1'b1});
    u_host.recv(1'b0, d[15:8]);
    u_host.recv(1'b1, d[7:0]);
    u_host.stop();
  endtask

  // every select and enable combination against the two register images
  task check_pins(input logic [7:0] hiReg, input logic [7:0] loReg);
    logic [7:0] sel;
    logic [1:0] bank;
    for (int i = 0; i < 4; i++) begin
      enPin <= i[1];
      voltageSelectPin <= i[0];
      repeat (6) @(posedge sys_clk);
      sel = i[0] ? hiReg : loReg;
      bank = i[0] ? rangeBankHigh : rangeBankLow;
      cmp(converterEnable, i[1] & sel[7], "enable");
      cmp(targetCode, sel[6:0], "code");
      cmp(targetBank, bank, "bank");
      cmp(targetMicrovolts, exp_uv(sel[6:0], bank), "target");
    end
  endtask

  initial begin
    repeat (95000) @(posedge sys_clk);
    err_count++;
    $display("MISMATCH at %0t: run did not finish", $time);
    complete_run();
  end

  initial begin
    err_count = 0;
    samples_checked = 0;
    srst = 1'b1;
    clkEn = 1'b1;
    enPin = 1'b0;
    voltageSelectPin = 1'b0;
    thermalTripIn = 1'b1;
    outputGoodIn = 1'b0;
    rangeBankHigh = 2'h3;
    rangeBankLow = 2'h1;
    repeat (4) @(posedge sys_clk);
    srst <= 1'b0;
    repeat (20) @(posedge sys_clk);
    check_pins(8'h97, 8'hBF);
    reg_read(8'h10, rd);
    cmp(rd, 16'h97BF, "reset images");
    reg_read(8'h01, rd);
    cmp(rd, 16'h8000, "hot status");
    reg_write(8'h01, 16'hFFFF);
    thermalTripIn <= 1'b0;
    outputGoodIn <= 1'b1;
    reg_read(8'h01, rd);
    cmp(rd, 16'h0100, "good status");
    reg_write(8'h10, 16'h55C0);
    check_pins(8'h55, 8'hC0);
    reg_read(8'h10, rd);
    cmp(rd, 16'h55C0, "written images");
    cmp(u_host.nackCount, 0, "acks");
    u_host.start();
    u_host.send({7'h1D, 1'b0});
    u_host.stop();
    cmp(u_host.nackCount, 1, "foreign address");
    cmp(sdaOut, 0, "open drain level");
    complete_run();
  end
endmodule
